// ### ecg_card_model.sv
// Behavioural card slot and NAND part on the far side of the glue.
// Assumes the bench sets the wait length before each card selection.
`timescale 1ns/10ps
`default_nettype none

module ecg_card_model (
    input  wire logic       core_clk_i,
    input  wire logic       card_enable_low_b_i,
    input  wire logic       card_enable_high_b_i,
    input  wire logic [7:0] wait_len_i,
    output logic            wait_b_o
);
    logic [7:0] left_reg  = 8'h00;
    logic       sel_d_reg = 1'b0;
    // Part enable is held low on a spare line, never dropped between accesses
    logic       nand_enable_b = 1'b0;
    wire  logic sel = !(card_enable_low_b_i && card_enable_high_b_i);

    // A slow card asks for wait from the first clock it is selected, for wait_len_i clocks
    always_ff @(posedge core_clk_i) begin
        sel_d_reg <= sel;
        if (sel && !sel_d_reg) begin
            left_reg <= wait_len_i;
        end else if (left_reg != 8'h00) begin
            left_reg <= left_reg - 8'h01;
        end
    end

    // Pulled up on the board, so released means high
    assign wait_b_o = (left_reg == 8'h00);
endmodule

`default_nettype wire

// ### ecg_glue.sv
// Card slot and NAND strobe glue behind the external bus pins.
// Assumes the static controller runs on core_clk_i; only the wait pin
// comes from outside and is synchronised. Every output is registered,
// so all pins lag the controller by one clock, uniformly.
//
// What this block and its software do
// [RL1] Software sets slot width to match access
// [RL2] Odd byte on low lane only 8-bit
// [RL3] Card enables follow slot chip select waveform
// [RL4] 16-bit common/IO: enables carry byte selects
// [RL5] Attribute mode: byte selects, odd byte lane too
// [RL6] 8-bit common/IO: high 1, low 0
// [RL7] IDE mode: high enable 1, low 0
// [RL8] Alternate IDE: high enable 0, low 1
// [RL9] Standby or unassigned: both enables high
// [RL10] I/O and IDE use I/O strobes
// [RL11] Memory modes use memory strobes only
// [RL12] IDE: memory read 0, write 1
// [RL13] Software sets setup/hold per card mode
// [RL14] Assign bit picks buffer or chip select
// [RL15] Shared pins carry card signals only then
// [RL16] Buffer select timed like slot chip select
// [RL17] Buffer direction valid whole transfer
// [RL18] Card wait extends the static access
// [RL19] NAND enabled by assign bit and space
// [RL20] NAND strobes follow static strobes
// [RL21] NAND strobes drop outside NAND space
// [RL22] NAND latches come from A22, A21
// [RL23] Software holds NAND enable on GPIO
// [RL24] Address bits 23:21 select card mode
// [RL25] ALE on A21, CLE on A22
// [RL26] Idle strobes rest high
`timescale 1ns/10ps
`default_nettype none

module ecg_glue
    import ecg_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        clk_en_i,
    input  wire logic        slot0_chip_select_b_i,
    input  wire logic        slot1_chip_select_b_i,
    input  wire logic        nand_chip_select_b_i,
    input  wire logic        static_read_strobe_b_i,
    input  wire logic        static_write_strobe_b_i,
    input  wire logic        byte_lane0_select_b_i,
    input  wire logic        byte_lane1_select_b_i,
    input  wire logic        byte_lane3_select_b_i,
    input  wire logic [31:0] xfer_addr_i,
    input  wire logic        xfer_read_i,
    input  wire logic        slot0_width16_i,
    input  wire logic        slot1_width16_i,
    input  wire logic        slot0_assign_bit_i,
    input  wire logic        slot1_assign_bit_i,
    input  wire logic        nand_assign_bit_i,
    input  wire logic        standby_i,
    input  wire logic        wait_request_in_b_i,
    output logic             slot0_pin_b_o,
    output logic             slot1_pin_b_o,
    output logic             card_enable_low_b_o,
    output logic             card_enable_high_b_o,
    output logic             rd_pin_b_o,
    output logic             wr_pin_b_o,
    output logic             lane1_pin_b_o,
    output logic             lane3_pin_b_o,
    output logic             a25_pin_o,
    output logic             nand_read_strobe_b_o,
    output logic             nand_write_strobe_b_o,
    output logic             nand_ale_o,
    output logic             nand_cle_o,
    output logic             static_wait_b_o
);

    logic      rst_s1_reg;
    logic      rst_n;
    logic      wait_s1_reg;
    logic      wait_s2_reg;
    logic      slot0_sel;
    logic      slot1_sel;
    logic      card_sel;
    logic      width16;
    logic      nand_sel;
    ecg_mode_e mode;
    logic [1:0] ce_next;
    logic      mem_rd_next;
    logic      mem_wr_next;
    logic      io_rd_next;
    logic      io_wr_next;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_s1_reg <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n      <= rst_s1_reg;
        end
    end

    // Wait pin is asynchronous to the core clock
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            wait_s1_reg <= 1'b1;
            wait_s2_reg <= 1'b1;
        end else if (clk_en_i) begin
            wait_s1_reg <= wait_request_in_b_i;
            wait_s2_reg <= wait_s1_reg;
        end
    end

    // Which space owns the current transfer
    always_comb begin
        slot0_sel = slot0_assign_bit_i && !slot0_chip_select_b_i;
        slot1_sel = slot1_assign_bit_i && !slot1_chip_select_b_i;
        card_sel  = slot0_sel || slot1_sel;
        width16   = slot0_sel ? slot0_width16_i : slot1_width16_i;
        mode      = ecg_mode_e'(
                        xfer_addr_i[ECG_MODE_MSB:ECG_MODE_LSB]);     // RL24
        nand_sel  = nand_assign_bit_i && !nand_chip_select_b_i       // RL19
                    && (xfer_addr_i[ECG_SPACE_MSB:ECG_SPACE_LSB]
                        == ECG_NAND_SPACE);
    end

    // Card enable pattern; a 0 in a fixed pattern is the chip select
    // itself, so the enables share its waveform
    always_comb begin
        ce_next = ECG_CE_IDLE;                                       // RL9
        if (card_sel && !standby_i) begin                            // RL3
            case (mode)
                ECG_MODE_ATTR: begin
                    ce_next = {byte_lane1_select_b_i,                // RL5
                               byte_lane0_select_b_i};
                end
                ECG_MODE_COMMON, ECG_MODE_IO: begin
                    if (width16) begin
                        ce_next = {byte_lane1_select_b_i,            // RL4
                                   byte_lane0_select_b_i};
                    end else begin
                        ce_next = ECG_CE_ODD8;                       // RL6
                    end
                end
                ECG_MODE_IDE: begin
                    ce_next = ECG_CE_ODD8;                           // RL7
                end
                ECG_MODE_ALT: begin
                    ce_next = ECG_CE_ALT;                            // RL8
                end
                default: begin
                    ce_next = ECG_CE_IDLE;
                end
            endcase
        end
    end

    // Card strobe routing per mode; reserved codes leave all idle
    always_comb begin
        mem_rd_next = 1'b1;
        mem_wr_next = 1'b1;
        io_rd_next  = 1'b1;
        io_wr_next  = 1'b1;
        if (card_sel) begin
            case (mode)
                ECG_MODE_ATTR, ECG_MODE_COMMON: begin
                    mem_rd_next = static_read_strobe_b_i;            // RL11
                    mem_wr_next = static_write_strobe_b_i;
                end
                ECG_MODE_IO: begin
                    io_rd_next = static_read_strobe_b_i;             // RL10
                    io_wr_next = static_write_strobe_b_i;
                end
                ECG_MODE_IDE, ECG_MODE_ALT: begin
                    mem_rd_next = 1'b0;                              // RL12
                    io_rd_next  = static_read_strobe_b_i;            // RL10
                    io_wr_next  = static_write_strobe_b_i;
                end
                default: begin
                    mem_rd_next = 1'b1;
                end
            endcase
        end
    end

    // Card enables
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            card_enable_high_b_o <= ECG_STROBE_RST;
            card_enable_low_b_o  <= ECG_STROBE_RST;
        end else if (clk_en_i) begin
            card_enable_high_b_o <= ce_next[1];                      // RL2
            card_enable_low_b_o  <= ce_next[0];
        end
    end

    // Slot pins: buffer select and chip select share one waveform,
    // only the consumer on the board changes with the assign bit
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            slot0_pin_b_o <= ECG_STROBE_RST;
            slot1_pin_b_o <= ECG_STROBE_RST;
        end else if (clk_en_i) begin
            slot0_pin_b_o <= slot0_assign_bit_i ?                    // RL14
                             slot0_chip_select_b_i :                 // RL16
                             slot0_chip_select_b_i;
            slot1_pin_b_o <= slot1_assign_bit_i ?
                             slot1_chip_select_b_i :
                             slot1_chip_select_b_i;
        end
    end

    // Shared pins revert to plain bus signals outside card accesses;
    // idle static strobes are high, so idle pins rest high too
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_pin_b_o    <= ECG_STROBE_RST;                         // RL26
            wr_pin_b_o    <= ECG_STROBE_RST;
            lane1_pin_b_o <= ECG_STROBE_RST;
            lane3_pin_b_o <= ECG_STROBE_RST;
            a25_pin_o     <= ECG_A25_RST;
        end else if (clk_en_i) begin
            if (card_sel) begin                                      // RL15
                rd_pin_b_o    <= mem_rd_next;
                wr_pin_b_o    <= mem_wr_next;
                lane1_pin_b_o <= io_rd_next;
                lane3_pin_b_o <= io_wr_next;
                a25_pin_o     <= xfer_read_i;                        // RL17
            end else begin
                rd_pin_b_o    <= static_read_strobe_b_i;
                wr_pin_b_o    <= static_write_strobe_b_i;
                lane1_pin_b_o <= byte_lane1_select_b_i;
                lane3_pin_b_o <= byte_lane3_select_b_i;
                a25_pin_o     <= xfer_addr_i[ECG_A25_BIT];
            end
        end
    end

    // NAND strobes and latch enables, cut as soon as the space is left
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            nand_read_strobe_b_o  <= ECG_STROBE_RST;
            nand_write_strobe_b_o <= ECG_STROBE_RST;
            nand_ale_o            <= ECG_LATCH_RST;
            nand_cle_o            <= ECG_LATCH_RST;
        end else if (clk_en_i) begin
            if (nand_sel) begin
                nand_read_strobe_b_o  <= static_read_strobe_b_i;     // RL20
                nand_write_strobe_b_o <= static_write_strobe_b_i;
                nand_ale_o <= xfer_addr_i[ECG_ALE_BIT];              // RL22
                nand_cle_o <= xfer_addr_i[ECG_CLE_BIT];              // RL25
            end else begin
                nand_read_strobe_b_o  <= 1'b1;                       // RL21
                nand_write_strobe_b_o <= 1'b1;
                nand_ale_o            <= 1'b0;
                nand_cle_o            <= 1'b0;
            end
        end
    end

    // Card wait forwarded to the controller; only card spaces stall,
    // so a floating slot wait line cannot hang NAND or other cycles
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            static_wait_b_o <= ECG_STROBE_RST;
        end else if (clk_en_i) begin
            static_wait_b_o <= !(card_sel && !wait_s2_reg);         // RL18
        end
    end

    // Checks on the registered pins, one clock after their cause
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n);

    sequence s_card(ecg_mode_e m);
        clk_en_i && card_sel && !standby_i && mode == m;
    endsequence

    sequence s_nand_off;
        clk_en_i && !nand_sel;
    endsequence

    a_standby_idle: assert property ( // RL9
        clk_en_i && (standby_i || !card_sel) |=>
            card_enable_high_b_o && card_enable_low_b_o)
        else $error("card enables not idle");

    a_attr_lanes: assert property ( // RL5
        s_card(ECG_MODE_ATTR) |=>
            {card_enable_high_b_o, card_enable_low_b_o} ==
            $past({byte_lane1_select_b_i, byte_lane0_select_b_i}))
        else $error("attribute enables not byte selects");

    a_common_narrow: assert property ( // RL6
        s_card(ECG_MODE_COMMON) and (!width16) |=>
            card_enable_high_b_o && !card_enable_low_b_o)
        else $error("8-bit common enables wrong");

    a_io_wide: assert property ( // RL4
        s_card(ECG_MODE_IO) and width16 |=>
            card_enable_high_b_o == $past(byte_lane1_select_b_i)
            && card_enable_low_b_o == $past(byte_lane0_select_b_i))
        else $error("16-bit io enables wrong");

    a_ide_enables: assert property ( // RL7
        s_card(ECG_MODE_IDE) |=>
            card_enable_high_b_o && !card_enable_low_b_o)
        else $error("ide enables wrong");

    a_alt_enables: assert property ( // RL8
        s_card(ECG_MODE_ALT) |=>
            !card_enable_high_b_o && card_enable_low_b_o)
        else $error("alternate ide enables wrong");

    a_ide_mem_fixed: assert property ( // RL12
        clk_en_i && card_sel && mode == ECG_MODE_IDE |=>
            !rd_pin_b_o && wr_pin_b_o
            && lane1_pin_b_o == $past(static_read_strobe_b_i))
        else $error("ide memory strobes not fixed");

    a_mem_io_idle: assert property ( // RL11
        clk_en_i && card_sel && mode == ECG_MODE_COMMON |=>
            lane1_pin_b_o && lane3_pin_b_o
            && rd_pin_b_o == $past(static_read_strobe_b_i))
        else $error("memory mode io strobes active");

    a_a25_revert: assert property ( // RL15
        clk_en_i && !card_sel |=>
            a25_pin_o == $past(xfer_addr_i[ECG_A25_BIT]))
        else $error("a25 pin not reverted");

    a_nand_outside: assert property ( // RL21
        s_nand_off |=> nand_read_strobe_b_o && nand_write_strobe_b_o
            && !nand_ale_o && !nand_cle_o)
        else $error("nand strobes outside space");

    a_nand_latch: assert property ( // RL25
        clk_en_i && nand_sel |=>
            nand_cle_o == $past(xfer_addr_i[ECG_CLE_BIT])
            && nand_ale_o == $past(xfer_addr_i[ECG_ALE_BIT])
            && nand_write_strobe_b_o
               == $past(static_write_strobe_b_i))
        else $error("nand latch enables wrong");

    a_wait_extend: assert property ( // RL18
        clk_en_i && !wait_request_in_b_i ##1 clk_en_i
            ##1 clk_en_i && card_sel |=> !static_wait_b_o)
        else $error("card wait not forwarded");

endmodule

`default_nettype wire

// ### ecg_glue_tb.sv
// Self-checking bench for the card and NAND strobe glue.
// Assumes one registered stage from controller inputs to every pin.
`timescale 1ns/10ps
`default_nettype none

module ecg_glue_tb;
    import ecg_pkg::*;
    logic        clk = 1'b0;
    logic        rst_b, clk_en, cs0_b, cs1_b, csn_b, rd_b, wr_b;
    logic        l0_b, l1_b, l3_b, xrd, w16_0, w16_1, as0, as1, asn;
    logic        stby, wait_b, p0_b, p1_b, cel_b, ceh_b, rdp_b, wrp_b;
    logic        l1p_b, l3p_b, a25, nrd_b, nwr_b, ale, cle, swait_b;
    logic [31:0] addr;
    logic [7:0]  wait_len;
    int          fails = 0;
    int          samples_checked = 0;
    ecg_mode_e   modes[5] = '{ECG_MODE_ATTR, ECG_MODE_COMMON, ECG_MODE_IO,
                              ECG_MODE_IDE, ECG_MODE_ALT};

    ecg_glue ecg_glue_inst (
        .core_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(clk_en),
        .slot0_chip_select_b_i(cs0_b), .slot1_chip_select_b_i(cs1_b),
        .nand_chip_select_b_i(csn_b), .static_read_strobe_b_i(rd_b),
        .static_write_strobe_b_i(wr_b), .byte_lane0_select_b_i(l0_b),
        .byte_lane1_select_b_i(l1_b), .byte_lane3_select_b_i(l3_b),
        .xfer_addr_i(addr), .xfer_read_i(xrd), .slot0_width16_i(w16_0),
        .slot1_width16_i(w16_1), .slot0_assign_bit_i(as0),
        .slot1_assign_bit_i(as1), .nand_assign_bit_i(asn),
        .standby_i(stby), .wait_request_in_b_i(wait_b),
        .slot0_pin_b_o(p0_b), .slot1_pin_b_o(p1_b),
        .card_enable_low_b_o(cel_b), .card_enable_high_b_o(ceh_b),
        .rd_pin_b_o(rdp_b), .wr_pin_b_o(wrp_b), .lane1_pin_b_o(l1p_b),
        .lane3_pin_b_o(l3p_b), .a25_pin_o(a25),
        .nand_read_strobe_b_o(nrd_b), .nand_write_strobe_b_o(nwr_b),
        .nand_ale_o(ale), .nand_cle_o(cle), .static_wait_b_o(swait_b));

    ecg_card_model ecg_card_model_inst (
        .core_clk_i(clk), .card_enable_low_b_i(cel_b),
        .card_enable_high_b_i(ceh_b), .wait_len_i(wait_len),
        .wait_b_o(wait_b));

    // Free-running 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t %s seen %0h want %0h",
                     $time, msg, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        if (fails == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Every mode, both widths, both slots, read then write
    task automatic t_card();
        logic       slot, w, rw, mem;
        logic [2:0] m;
        logic [1:0] en;
        logic [3:0] sx;
        for (int i = 0; i < 40; i++) begin
            slot = (i / 20) != 0;
            w = ((i / 10) % 2) != 0;
            rw = ((i / 5) % 2) != 0;
            m = modes[i % 5];
            {as0, as1, l0_b, l1_b, l3_b} = 5'h1C;
            {cs0_b, cs1_b} = {slot, !slot};
            w16_0 = w ^ slot;
            w16_1 = w ^ !slot;
            {rd_b, wr_b, xrd} = {rw, !rw, !rw};
            addr = {slot ? 4'h6 : 4'h5, 2'h0, rw, 1'b0, m, 21'h0};
            @(negedge clk);
            mem = (m == ECG_MODE_ATTR) || (m == ECG_MODE_COMMON);
            en = (m == ECG_MODE_ATTR || m == ECG_MODE_ALT ||
                  (w && (m == ECG_MODE_COMMON || m == ECG_MODE_IO)))
                 ? 2'h1 : 2'h2;
            check({ceh_b, cel_b}, en, "ce");
            check({p0_b, p1_b}, {slot, !slot}, "slot pins");
            sx = {mem ? rd_b : (m == ECG_MODE_IO), mem ? wr_b : 1'b1,
                  mem ? 1'b1 : rd_b, mem ? 1'b1 : wr_b};
            check({rdp_b, wrp_b, l1p_b, l3p_b}, sx, "pins");
            check(a25, xrd, "direction");
        end
        {cs0_b, cs1_b} = 2'h3;
    endtask

    // Unassigned slot and standby leave the card idle
    task automatic t_plain();
        // Direction low and address bit high, so a25 tells them apart
        {as0, cs0_b, rd_b, wr_b, l1_b, l3_b, xrd} = 7'h0A;
        addr = 32'h5240_0000;
        @(negedge clk);
        check({ceh_b, cel_b}, 2'h3, "unassigned enables");
        check({p0_b, rdp_b, wrp_b}, 3'h1, "plain");
        check({l1p_b, l3p_b, a25}, 3'h3, "plain lanes");
        {as0, stby} = 2'h3;
        @(negedge clk);
        check({ceh_b, cel_b}, 2'h3, "standby enables");
        // Reserved mode code in a selected slot leaves card idle
        {stby, addr} = {1'b0, 32'h5020_0000};
        @(negedge clk);
        check({ceh_b, cel_b, rdp_b, l1p_b}, 4'hF, "reserved");
        {stby, cs0_b, rd_b} = 3'h3;
        @(negedge clk);
        check({p0_b, ceh_b, cel_b, rdp_b}, 4'hF, "idle");
    endtask

    task automatic nand_step(input logic [31:0] a, input logic [3:0] exp);
        addr = a;
        @(negedge clk);
        check({nrd_b, nwr_b, ale, cle}, exp, "nand");
    endtask

    // Latches from address, strobes only inside the assigned space
    task automatic t_nand();
        {asn, csn_b, rd_b, wr_b} = 4'h9;
        nand_step(32'h4060_0000, 4'h7);
        {rd_b, wr_b} = 2'h2;
        nand_step(32'h4020_0000, 4'hA);
        nand_step(32'h5020_0000, 4'hC);
        asn = 1'b0;
        nand_step(32'h4040_0000, 4'hC);
        {asn, csn_b, wr_b} = 3'h7;
        nand_step(32'h4040_0000, 4'hC);
    endtask

    // A frozen enable holds the pins, then the edge lands
    task automatic t_clk_en();
        {clk_en, cs0_b} = 2'h0;
        addr = 32'h5040_0000;
        @(negedge clk);
        check(p0_b, 1'b1, "frozen");
        clk_en = 1'b1;
        @(negedge clk);
        check({p0_b, ceh_b}, 2'h1, "thawed");
        cs0_b = 1'b1;
        @(negedge clk);
    endtask

    // Card wait must stretch the access exactly as long as it is held
    task automatic t_wait();
        int n;
        wait_len = 8'h04;
        cs0_b = 1'b0;
        for (int i = 0; i < 8 && swait_b !== 1'b0; i++) @(negedge clk);
        // A timeout is counted and falls through to the closing report
        if (swait_b !== 1'b0) begin
            check(1, 0, "wait never seen");
        end else begin
            n = 0;
            for (int i = 0; i < 10; i++) begin
                if (swait_b === 1'b0) n++;
                @(negedge clk);
            end
            check(n, 4, "wait length");
        end
        {cs0_b, wait_len} = 9'h100;
        @(negedge clk);
    endtask

    // Reset, then each scenario in turn
    initial begin
        {rst_b, clk_en, addr, wait_len} = 42'h100_0000_0000;
        {cs0_b, cs1_b, csn_b, rd_b, wr_b, l0_b, l1_b, l3_b} = 8'hFF;
        {xrd, w16_0, w16_1, as0, as1, asn, stby} = 7'h00;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        check({p0_b, cel_b, ceh_b, nrd_b, ale, cle}, 6'h3C, "rst");
        t_card();
        t_plain();
        t_nand();
        t_clk_en();
        t_wait();
        report_and_stop();
    end
endmodule

`default_nettype wire

// ### ecg_pkg.sv
// Constants for the card and NAND strobe glue.
// Assumes the address bus is the full 32-bit transfer address.
package ecg_pkg;

    // Card mode codes taken from the mode field of the address
    typedef enum logic [2:0] {
        ECG_MODE_ATTR   = 3'h0,
        ECG_MODE_COMMON = 3'h2,
        ECG_MODE_IO     = 3'h4,
        ECG_MODE_IDE    = 3'h6,
        ECG_MODE_ALT    = 3'h7
    } ecg_mode_e;

    // Address field positions
    localparam int unsigned ECG_MODE_MSB  = 23;
    localparam int unsigned ECG_MODE_LSB  = 21;
    localparam int unsigned ECG_ALE_BIT   = 21;
    localparam int unsigned ECG_CLE_BIT   = 22;
    localparam int unsigned ECG_A25_BIT   = 25;
    localparam int unsigned ECG_SPACE_MSB = 31;
    localparam int unsigned ECG_SPACE_LSB = 28;

    // Top nibble of the NAND space, 0x4000_0000 to 0x4FFF_FFFF
    localparam logic [3:0] ECG_NAND_SPACE = 4'h4;

    // Fixed enable patterns {high, low}
    localparam logic [1:0] ECG_CE_IDLE  = 2'h3;
    localparam logic [1:0] ECG_CE_ODD8  = 2'h2;
    localparam logic [1:0] ECG_CE_ALT   = 2'h1;

    // Reset values of the pins
    localparam logic ECG_STROBE_RST = 1'h1;
    localparam logic ECG_LATCH_RST  = 1'h0;
    localparam logic ECG_A25_RST    = 1'h0;

endpackage
